// *** logic/adcc_clkgen.sv ***
module adcc_clkgen
    import adcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic async_clk_in,
    input wire logic alt_clk_in,
    input wire logic [1:0] clk_src_in,
    input wire logic [1:0] clk_div_in,
    input wire logic deep_stop_in,
    input wire logic run_ok_in,
    output logic alt_edge_out,
    adcc_conv_if.gen conv
);
    logic [2:0] async_sync;
    logic [2:0] alt_sync;
    logic half;
    logic [2:0] div_cnt;
    logic base_tick;
    wire async_edge = async_sync[1] & ~async_sync[2];
    wire [2:0] div_last = 3'((4'h1 << clk_div_in) - 4'h1);

    // synchronise outside clocks, bus half-rate toggle, divider
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            async_sync <= 3'h0;
            alt_sync <= 3'h0;
            half <= 1'b0;
            div_cnt <= 3'h0;
        end else if (clk_en_in) begin
            async_sync <= {async_sync[1:0], async_clk_in};
            alt_sync <= {alt_sync[1:0], alt_clk_in};
            half <= ~half;
            if (base_tick) begin
                div_cnt <= conv.tick ? 3'h0 : div_cnt + 3'h1;
            end
        end
    end

    assign alt_edge_out = alt_sync[1] & ~alt_sync[2];

    // source select; four sources, alternate blocked in deep stop
    always_comb begin
        unique case (adcc_clksrc_e'(clk_src_in))
            CKS_BUS: base_tick = run_ok_in;
            CKS_BUS_HALF: base_tick = run_ok_in & half;
            CKS_ASYNC: base_tick = run_ok_in & async_edge;
            CKS_ALT: base_tick = run_ok_in & alt_edge_out & ~deep_stop_in;
        endcase
    end

    assign conv.tick = base_tick & (div_cnt == div_last);

    // alternate clock silent in deep stop
    AST_ALT_STOP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (deep_stop_in && clk_src_in == 2'h3) |-> !conv.tick)
        else $error("alternate clock ticked in deep stop");
endmodule

// *** logic/adcc_conv_if.sv ***
// link between sequencer, clock generator and approximation engine
interface adcc_conv_if;
    logic tick;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic [9:0] result;
    modport gen (output tick);
    modport sar (input tick, input start, input abort, output busy, output done, output result);
    modport ctl (input tick, output start, output abort, input busy, input done, input result);
endinterface

// *** logic/adcc_pkg.sv ***
// Behaviour
// - select codes 00000-01111 route external pins zero to fifteen in order
// - each external channel has its own pin enable bit handing the pin over
// - codes 10000-10101 are tied to the low reference internally
// - reserved codes 10110-11001 and 11100 still convert, result undefined
// - conversion clock chosen from bus, half bus, local async or alternate clock
// - conversion clock from any of the four sources is divided by the divide select ratio
// - alternate clock works in wait but never clocks conversions in deep stop
// - hardware trigger from periodic counter overflow at the rate select period
// - trigger on the first overflow, then on every second overflow after it
// - trigger counter runs on reference clock or 1 kHz; only 1 kHz in stop
// - each sample resolved by linear successive approximation to 10 bits
// - result right-justified in ten-bit or eight-bit format as configured
// - single or continuous conversion; single returns to idle by itself, or to armed when hardware trigger is enabled
// - automatic compare against a value, less-than or greater-or-equal sense
// - conversion complete flag with a matching interrupt request
// - pin enable bits are held in exactly two pin control registers
// - control write aborts current conversion and starts anew (arms instead with hardware trigger) unless all ones
// - all-ones select turns converter off with no extra conversion
package adcc_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SLOW_SRC_HZ = 1000;
    localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_SRC_HZ;
    localparam int RES_BITS = 10;
    localparam logic [4:0] CH_PIN_LAST = 5'h0f;
    localparam logic [4:0] CH_TIE_FIRST = 5'h10;
    localparam logic [4:0] CH_TIE_LAST = 5'h15;
    localparam logic [4:0] CH_RSV_FIRST = 5'h16;
    localparam logic [4:0] CH_RSV_LAST = 5'h19;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BGAP = 5'h1b;
    localparam logic [4:0] CH_RSV_LONE = 5'h1c;
    localparam logic [4:0] CH_REFH = 5'h1d;
    localparam logic [4:0] CH_REFL = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;
    localparam logic [4:0] CH_RST = 5'h1f;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] SAR_MSB = 10'h200;
    localparam logic [1:0] SETTLE_CYC = 2'h3;
    localparam logic [10:0] RATE_BASE_TICKS = 11'h010;
    typedef enum logic [1:0] {CKS_BUS, CKS_BUS_HALF, CKS_ASYNC, CKS_ALT} adcc_clksrc_e;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} adcc_state_e;

    // eight-bit mode keeps the upper eight result bits, right-justified
    function automatic logic [9:0] adcc_fmt(input logic [9:0] res, input logic mode8);
        adcc_fmt = mode8 ? {2'h0, res[9:2]} : res;
    endfunction

    // inclusive range check on a select code
    function automatic logic adcc_in_range(input logic [4:0] ch, input logic [4:0] lo,
                                           input logic [4:0] hi);
        adcc_in_range = (ch >= lo) && (ch <= hi);
    endfunction
endpackage

// *** logic/adcc_sar.sv ***
module adcc_sar
    import adcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic cmp_in,
    output logic [9:0] dac_code_out,
    output logic sample_out,
    adcc_conv_if.sar conv
);
    logic [9:0] mask;
    logic [1:0] settle;
    logic [1:0] cmp_sync;
    wire step = conv.busy & conv.tick & (settle == 2'h0);
    // comparator high keeps the trial bit
    wire [9:0] kept = cmp_sync[1] ? dac_code_out : (dac_code_out & ~mask);

    // linear successive approximation, one bit per settled tick
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_sync <= 2'h0;
            conv.busy <= 1'b0;
            conv.done <= 1'b0;
            conv.result <= RESULT_RST;
            dac_code_out <= RESULT_RST;
            sample_out <= 1'b0;
            mask <= SAR_MSB;
            settle <= 2'h0;
        end else if (clk_en_in) begin
            cmp_sync <= {cmp_sync[0], cmp_in};
            // a start or abort in the last step cycle drops the done pulse
            conv.done <= step & ~sample_out & mask[0] & ~conv.start & ~conv.abort;
            if (settle != 2'h0) begin
                settle <= settle - 2'h1;
            end
            if (conv.start) begin
                conv.busy <= 1'b1;
                sample_out <= 1'b1;
                dac_code_out <= RESULT_RST;
                mask <= SAR_MSB;
                settle <= 2'h0;
            end else if (conv.abort) begin
                conv.busy <= 1'b0;
                sample_out <= 1'b0;
            end else if (step && sample_out) begin
                sample_out <= 1'b0;
                dac_code_out <= mask;
                settle <= SETTLE_CYC;
            end else if (step && mask[0]) begin
                conv.busy <= 1'b0;
                conv.result <= kept;
                dac_code_out <= kept;
            end else if (step) begin
                dac_code_out <= kept | (mask >> 1);
                mask <= mask >> 1;
                settle <= SETTLE_CYC;
            end
        end
    end

    // a done pulse ends the least significant decision
    AST_SAR_LSB: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
        conv.done |-> !conv.busy && $past(mask[0]))
        else $error("conversion ended before the last bit");
endmodule

// *** logic/adcc_top.sv ***
module adcc_top
    import adcc_pkg::*;
#(
    parameter int SLOW_DIV = SLOW_DIV_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic ctrl_wr_in,
    input wire logic [4:0] channel_select_field_in,
    input wire logic cont_conv_in,
    input wire logic int_en_in,
    input wire logic result_rd_in,
    input wire logic hw_trig_en_in,
    input wire logic cmp_en_in,
    input wire logic cmp_ge_in,
    input wire logic [9:0] cmp_val_in,
    input wire logic mode8_in,
    input wire logic [1:0] clk_src_in,
    input wire logic [1:0] clock_divide_select_in,
    input wire logic [7:0] analog_pin_ctrl_low_in,
    input wire logic [7:0] analog_pin_ctrl_high_in,
    input wire logic async_clk_in,
    input wire logic alternate_conv_clock_in,
    input wire logic wake_src_ext_in,
    input wire logic [2:0] periodic_rate_select_in,
    input wire logic wait_mode_in,
    input wire logic deep_stop_in,
    input wire logic low_volt_detect_enable_in,
    input wire logic low_volt_detect_stop_enable_in,
    input wire logic cmp_in,
    output logic [15:0] pin_grant_out,
    output logic [15:0] ext_pin_sel_out,
    output logic ref_low_sel_out,
    output logic ref_high_sel_out,
    output logic temp_sel_out,
    output logic bandgap_sel_out,
    output logic reserved_sel_out,
    output logic converter_on_out,
    output logic [9:0] dac_code_out,
    output logic sample_out,
    output logic busy_out,
    output logic [9:0] result_out,
    output logic conversion_done_flag_out,
    output logic irq_out,
    output logic hw_conversion_trigger_out
);
    adcc_conv_if conv ();

    adcc_state_e state;
    adcc_state_e next_state;
    logic [4:0] ch;
    logic [14:0] slow_cnt;
    logic [10:0] wake_cnt;
    logic wake_level;

    // deep stop conversions only with both detect enables (software duty)
    // stop qualification
    wire run_ok = ~deep_stop_in | (low_volt_detect_enable_in & low_volt_detect_stop_enable_in);
    wire alt_edge;

    adcc_clkgen u_clkgen (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .async_clk_in(async_clk_in),
        .alt_clk_in(alternate_conv_clock_in),
        .clk_src_in(clk_src_in),
        .clk_div_in(clock_divide_select_in),
        .deep_stop_in(deep_stop_in),
        .run_ok_in(run_ok),
        .alt_edge_out(alt_edge),
        .conv(conv.gen)
    );

    adcc_sar u_sar (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .cmp_in(cmp_in),
        .dac_code_out(dac_code_out),
        .sample_out(sample_out),
        .conv(conv.sar)
    );

    // channel decode of the held select code
    // external pins 0-15
    wire ch_pin = (ch <= CH_PIN_LAST);
    // unimplemented codes tied low, explicit low reference
    wire ch_low = adcc_in_range(ch, CH_TIE_FIRST, CH_TIE_LAST) | (ch == CH_REFL);
    wire ch_rsv = adcc_in_range(ch, CH_RSV_FIRST, CH_RSV_LAST) | (ch == CH_RSV_LONE);
    // all ones switches the converter off
    wire wr_off = (channel_select_field_in == CH_OFF);

    // slow source divider, nominal 1 kHz tick
    wire slow_tick = (slow_cnt == 15'(SLOW_DIV - 1));
    // reference clock stops in deep stop, slow source keeps running
    wire wake_tick = wake_src_ext_in ? (alt_edge & ~deep_stop_in) : slow_tick;
    // overflow period set by rate select
    wire [10:0] wake_last = 11'((RATE_BASE_TICKS << periodic_rate_select_in) - 11'h001);
    wire wake_ovf = wake_tick & (wake_cnt == wake_last);
    // trigger on rising counter output: first overflow, then every second
    wire hw_trig = wake_ovf & ~wake_level;

    // periodic counter for the hardware trigger
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slow_cnt <= 15'h0000;
            wake_cnt <= 11'h000;
            wake_level <= 1'b0;
        end else if (clk_en_in) begin
            slow_cnt <= slow_tick ? 15'h0000 : slow_cnt + 15'h0001;
            if (wake_tick) begin
                wake_cnt <= wake_ovf ? 11'h000 : wake_cnt + 11'h001;
            end
            if (wake_ovf) begin
                wake_level <= ~wake_level;
            end
        end
    end

    assign hw_conversion_trigger_out = hw_trig;

    // result formatting and compare
    // ten or eight bit right-justified
    wire [9:0] res_fmt = adcc_fmt(conv.result, mode8_in);
    wire cmp_true = cmp_ge_in ? (res_fmt >= cmp_val_in) : (res_fmt < cmp_val_in);
    wire flag_set = conv.done & (~cmp_en_in | cmp_true);
    wire flag_clr = ctrl_wr_in | result_rd_in;

    // conversion sequencer
    always_comb begin
        next_state = state;
        conv.start = 1'b0;
        conv.abort = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_state = ST_IDLE;
            end
            // armed conversion waits for a trigger
            ST_ARMED: begin
                if (hw_trig && run_ok) begin
                    conv.start = 1'b1;
                    next_state = ST_CONV;
                end
            end
            // continuous restarts, single returns by itself
            ST_CONV: begin
                if (conv.done && cont_conv_in) begin
                    conv.start = 1'b1;
                end else if (conv.done) begin
                    next_state = hw_trig_en_in ? ST_ARMED : ST_IDLE;
                end
            end
        endcase
        if (ctrl_wr_in) begin
            conv.abort = 1'b1;
            conv.start = 1'b0;
            if (wr_off) begin
                next_state = ST_IDLE;
            end else if (hw_trig_en_in) begin
                next_state = ST_ARMED;
            end else begin
                conv.start = 1'b1;
                next_state = ST_CONV;
            end
        end
    end

    // state, held select code, result and flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            ch <= CH_RST;
            result_out <= RESULT_RST;
            conversion_done_flag_out <= 1'b0;
        end else if (clk_en_in) begin
            state <= next_state;
            if (ctrl_wr_in) begin
                ch <= channel_select_field_in;
            end
            if (flag_set) begin
                result_out <= res_fmt;
            end
            // set wins over a clearing write or read
            conversion_done_flag_out <= flag_set | (conversion_done_flag_out & ~flag_clr);
        end
    end

    // routing outputs registered from the held code, pin grants from pin control
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_grant_out <= 16'h0000;
            ext_pin_sel_out <= 16'h0000;
            ref_low_sel_out <= 1'b0;
            ref_high_sel_out <= 1'b0;
            temp_sel_out <= 1'b0;
            bandgap_sel_out <= 1'b0;
            reserved_sel_out <= 1'b0;
            converter_on_out <= 1'b0;
        end else if (clk_en_in) begin
            // one enable per pin, two pin control registers
            pin_grant_out <= {analog_pin_ctrl_high_in, analog_pin_ctrl_low_in};
            ext_pin_sel_out <= ch_pin ? (16'h0001 << ch[3:0]) : 16'h0000;
            ref_low_sel_out <= ch_low;
            ref_high_sel_out <= (ch == CH_REFH);
            temp_sel_out <= (ch == CH_TEMP);
            bandgap_sel_out <= (ch == CH_BGAP);
            reserved_sel_out <= ch_rsv;
            converter_on_out <= (ch != CH_OFF);
        end
    end

    assign busy_out = conv.busy;
    assign irq_out = conversion_done_flag_out & int_en_in;

    // checks on the sequencer and routing
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in || !clk_en_in);

    AST_PIN_ROUTE: assert property ((ch <= CH_PIN_LAST) && $stable(ch) |=>
        ext_pin_sel_out == (16'h0001 << $past(ch[3:0])))
        else $error("pin route does not match select code");

    AST_PIN_GRANT: assert property (##1 pin_grant_out ==
        $past({analog_pin_ctrl_high_in, analog_pin_ctrl_low_in}))
        else $error("pin grant not taken from pin control");

    AST_TIE_LOW: assert property (ch >= CH_TIE_FIRST && ch <= CH_TIE_LAST && $stable(ch)
        |=> ref_low_sel_out && ext_pin_sel_out == 16'h0000)
        else $error("unimplemented code not tied low");

    AST_RSV_CONV: assert property (ctrl_wr_in && !hw_trig_en_in &&
        ((channel_select_field_in >= CH_RSV_FIRST && channel_select_field_in <= CH_RSV_LAST)
        || channel_select_field_in == CH_RSV_LONE) |=> state == ST_CONV && busy_out)
        else $error("reserved code did not convert");

    AST_WR_RESTART: assert property (ctrl_wr_in && !wr_off && !hw_trig_en_in
        |=> busy_out && sample_out && (!conversion_done_flag_out || $past(flag_set)))
        else $error("control write did not restart conversion");

    AST_OFF_QUIET: assert property (ctrl_wr_in && wr_off |=>
        state == ST_IDLE && !busy_out ##1 !converter_on_out)
        else $error("all-ones select left converter running");

    AST_SINGLE_IDLE: assert property (state == ST_CONV && conv.done && !cont_conv_in
        && !hw_trig_en_in && !ctrl_wr_in |=> state == ST_IDLE && !busy_out)
        else $error("single conversion did not return to idle");

    AST_CMP_GATE: assert property (conv.done && cmp_en_in && !cmp_true &&
        !conversion_done_flag_out |=> !conversion_done_flag_out)
        else $error("flag set although compare failed");

    AST_FLAG_SET: assert property (flag_set |=> conversion_done_flag_out &&
        result_out == $past(res_fmt))
        else $error("finished conversion not flagged");

    AST_TRIG_ALT: assert property (hw_trig |-> wake_ovf && !wake_level ##1 wake_level)
        else $error("trigger not on rising counter output");

    AST_STOP_HOLD: assert property (deep_stop_in && !run_ok |-> !conv.tick)
        else $error("conversion clock ran in unqualified deep stop");

    AST_ARMED_WAIT: assert property (state == ST_ARMED && !hw_trig && !ctrl_wr_in
        |=> state == ST_ARMED && !busy_out)
        else $error("armed conversion started without trigger");
endmodule

// *** verif/adcc_analog_model.sv ***
// ideal analog side: sources behind the mux and the comparator
module adcc_analog_model (
    input wire logic clk_in,
    input wire logic [9:0] dac_code_in,
    input wire logic [15:0] ext_pin_sel_in,
    input wire logic ref_low_sel_in,
    input wire logic ref_high_sel_in,
    input wire logic temp_sel_in,
    input wire logic bandgap_sel_in,
    output logic cmp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] level;
    logic wobble = 1'b0;
    logic any_sel;

    // nothing routed: comparator output wanders every cycle
    always @(posedge clk_in) begin
        wobble <= ~wobble;
    end

    // source levels seen by the converter
    always_comb begin
        level = 10'h000;
        for (int i = 0; i < 16; i++) begin
            if (ext_pin_sel_in[i]) begin
                level = {i[3:0], 6'h2b};
            end
        end
        if (bandgap_sel_in) begin
            level = 10'h155;
        end
        if (temp_sel_in) begin
            level = 10'h2aa;
        end
        if (ref_high_sel_in) begin
            level = 10'h3ff;
        end
        if (ref_low_sel_in) begin
            level = 10'h000;
        end
    end

    assign any_sel = (|ext_pin_sel_in) | ref_low_sel_in | ref_high_sel_in | temp_sel_in
                     | bandgap_sel_in;
    assign cmp_out = any_sel ? (level >= dac_code_in) : wobble;
endmodule

// *** verif/adcc_top_tb.sv ***
module adcc_top_tb
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SDIV = 8;
    logic clk_in = 0, rst_n_in = 0, ctrl_wr_in = 0, cont_conv_in = 0, int_en_in = 0;
    logic result_rd_in = 0, hw_trig_en_in = 0, cmp_en_in = 0, cmp_ge_in = 0, mode8_in = 0;
    logic async_clk_in = 0, alt_clk = 0, wake_src_ext_in = 0, deep_stop_in = 0;
    logic lvd_en = 0, lvd_stop_en = 0, cmp_in;
    logic [4:0] channel_select_field_in = 5'h00;
    logic [9:0] cmp_val_in = 10'h000;
    logic [1:0] clk_src_in = 2'h0, div_sel = 2'h0;
    logic [7:0] pin_lo = 8'h00, pin_hi = 8'h00;
    logic [2:0] rate_sel = 3'h0;
    logic [15:0] pin_grant, ext_sel;
    logic ref_lo, ref_hi, temp_sel, bg_sel, rsv_sel, conv_on, sample, busy, flag, irq, trig;
    logic [9:0] dac_code, result;
    int error_cnt = 0, n_checks = 0, cyc = 0;

    always #25 clk_in = ~clk_in;
    always #55 async_clk_in = ~async_clk_in;
    always #115 alt_clk = ~alt_clk; // reference clock kept running

    adcc_top #(.SLOW_DIV(SDIV)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .ctrl_wr_in(ctrl_wr_in), .channel_select_field_in(channel_select_field_in),
        .cont_conv_in(cont_conv_in), .int_en_in(int_en_in), .result_rd_in(result_rd_in),
        .hw_trig_en_in(hw_trig_en_in), .cmp_en_in(cmp_en_in), .cmp_ge_in(cmp_ge_in),
        .cmp_val_in(cmp_val_in), .mode8_in(mode8_in), .clk_src_in(clk_src_in),
        .clock_divide_select_in(div_sel), .analog_pin_ctrl_low_in(pin_lo),
        .analog_pin_ctrl_high_in(pin_hi), .async_clk_in(async_clk_in),
        .alternate_conv_clock_in(alt_clk), .wake_src_ext_in(wake_src_ext_in),
        .periodic_rate_select_in(rate_sel), .wait_mode_in(1'b0), .deep_stop_in(deep_stop_in),
        .low_volt_detect_enable_in(lvd_en), .low_volt_detect_stop_enable_in(lvd_stop_en),
        .cmp_in(cmp_in), .pin_grant_out(pin_grant), .ext_pin_sel_out(ext_sel),
        .ref_low_sel_out(ref_lo), .ref_high_sel_out(ref_hi), .temp_sel_out(temp_sel),
        .bandgap_sel_out(bg_sel), .reserved_sel_out(rsv_sel), .converter_on_out(conv_on),
        .dac_code_out(dac_code), .sample_out(sample), .busy_out(busy), .result_out(result),
        .conversion_done_flag_out(flag), .irq_out(irq), .hw_conversion_trigger_out(trig));

    adcc_analog_model model (.clk_in(clk_in), .dac_code_in(dac_code), .ext_pin_sel_in(ext_sel),
        .ref_low_sel_in(ref_lo), .ref_high_sel_in(ref_hi), .temp_sel_in(temp_sel),
        .bandgap_sel_in(bg_sel), .cmp_out(cmp_in));

    // cycle count and hang guard
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [9:0] lvl(input int n);
        lvl = {n[3:0], 6'h2b};
    endfunction

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [4:0] c);
        @(posedge clk_in);
        ctrl_wr_in <= 1'b1;
        channel_select_field_in <= c;
        @(posedge clk_in);
        ctrl_wr_in <= 1'b0;
    endtask

    task rd();
        @(posedge clk_in);
        result_rd_in <= 1'b1;
        @(posedge clk_in);
        result_rd_in <= 1'b0;
    endtask

    task wait_flag(input int n, output logic got);
        got = 1'b0;
        repeat (n) begin
            @(negedge clk_in);
            if (flag === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
    endtask

    task conv(input logic [4:0] c, input int n, output logic got);
        wr(c);
        wait_flag(n, got);
    endtask

    task next_trig(output int t);
        t = -1;
        repeat (1000) begin
            @(negedge clk_in);
            if (trig === 1'b1) begin
                t = cyc;
                break;
            end
        end
    endtask

    task t_pins();
        logic f;
        pin_lo <= 8'ha5;
        pin_hi <= 8'h3c;
        repeat (3) @(negedge clk_in);
        chk(pin_grant, 16'h3ca5);
        for (int i = 0; i < 16; i++) begin
            conv(i[4:0], 3000, f);
            chk({15'h0, f}, 16'h1);
            chk({6'h0, result}, {6'h0, lvl(i)});
            chk(ext_sel, 16'h1 << i);
            chk({15'h0, busy}, 16'h0);
        end
        $display("test pins done");
    endtask

    task t_inner();
        logic f;
        logic [4:0] cs[4] = '{CH_REFH, CH_REFL, CH_TEMP, CH_BGAP};
        logic [9:0] es[4] = '{10'h3ff, 10'h000, 10'h2aa, 10'h155};
        for (int c = 16; c <= 21; c++) begin
            conv(c[4:0], 3000, f);
            chk({6'h0, result}, 16'h0);
            chk({15'h0, ref_lo}, 16'h1);
        end
        for (int k = 0; k < 4; k++) begin
            conv(cs[k], 3000, f);
            chk({6'h0, result}, {6'h0, es[k]});
        end
        for (int c = 22; c <= 28; c++) begin
            if (c == 26 || c == 27) continue;
            conv(c[4:0], 3000, f);
            chk({15'h0, f}, 16'h1);
            chk({15'h0, rsv_sel}, 16'h1);
        end
        $display("test inner channels done");
    endtask

    task t_off();
        logic f;
        cont_conv_in <= 1'b1;
        conv(5'h03, 3000, f);
        rd();
        wait_flag(3000, f);
        chk({15'h0, f}, 16'h1);
        wr(CH_OFF);
        repeat (2) @(negedge clk_in);
        chk({15'h0, busy}, 16'h0);
        chk({15'h0, conv_on}, 16'h0);
        wait_flag(300, f);
        chk({15'h0, f}, 16'h0);
        cont_conv_in <= 1'b0;
        $display("test off done");
    endtask

    task t_abort_fmt();
        logic f;
        wr(5'h04);
        @(negedge clk_in);
        chk({15'h0, busy}, 16'h1);
        repeat (10) @(posedge clk_in);
        conv(5'h07, 3000, f);
        chk({6'h0, result}, {6'h0, lvl(7)});
        mode8_in <= 1'b1;
        conv(5'h09, 3000, f);
        chk({6'h0, result}, {6'h0, lvl(9) >> 2});
        mode8_in <= 1'b0;
        $display("test abort and format done");
    endtask

    task t_cmp_irq();
        logic f;
        cmp_en_in <= 1'b1;
        cmp_ge_in <= 1'b1;
        cmp_val_in <= lvl(5);
        conv(5'h05, 3000, f);
        chk({15'h0, f}, 16'h1);
        cmp_val_in <= lvl(5) + 10'h001;
        conv(5'h05, 300, f);
        chk({15'h0, f}, 16'h0);
        cmp_ge_in <= 1'b0;
        conv(5'h05, 3000, f);
        chk({15'h0, f}, 16'h1);
        cmp_en_in <= 1'b0;
        int_en_in <= 1'b1;
        conv(5'h06, 3000, f);
        chk({15'h0, irq}, 16'h1);
        rd();
        @(negedge clk_in);
        chk({14'h0, flag, irq}, 16'h0);
        int_en_in <= 1'b0;
        $display("test compare and irq done");
    endtask

    task t_clk_stop();
        logic f;
        for (int s = 0; s < 4; s++) begin
            clk_src_in <= s[1:0];
            div_sel <= s[1:0];
            conv(5'(8 + s), 5000, f);
            chk({15'h0, f}, 16'h1);
            chk({6'h0, result}, {6'h0, lvl(8 + s)});
        end
        clk_src_in <= 2'h0;
        div_sel <= 2'h0;
        deep_stop_in <= 1'b1;
        conv(5'h01, 300, f);
        chk({15'h0, f}, 16'h0);
        lvd_en <= 1'b1;
        lvd_stop_en <= 1'b1;
        wait_flag(3000, f);
        chk({15'h0, f}, 16'h1);
        clk_src_in <= 2'h3;
        conv(5'h0b, 400, f);
        chk({15'h0, f}, 16'h0);
        deep_stop_in <= 1'b0;
        wait_flag(3000, f);
        chk({6'h0, result}, {6'h0, lvl(11)});
        clk_src_in <= 2'h0;
        $display("test clocks and stop done");
    endtask

    task t_hw();
        logic f;
        int t1, t2, n;
        hw_trig_en_in <= 1'b1;
        wr(5'h02);
        @(negedge clk_in);
        chk({15'h0, busy}, 16'h0);
        next_trig(t1);
        next_trig(t2);
        chk(16'(t2 - t1), 16'(2 * 16 * SDIV));
        wait_flag(3000, f);
        chk({6'h0, result}, {6'h0, lvl(2)});
        wake_src_ext_in <= 1'b1;
        deep_stop_in <= 1'b1;
        n = 0;
        repeat (800) begin
            @(negedge clk_in);
            if (trig === 1'b1) n++;
        end
        chk(16'(n), 16'h0);
        wake_src_ext_in <= 1'b0;
        next_trig(t1);
        chk({15'h0, t1 >= 0}, 16'h1);
        hw_trig_en_in <= 1'b0;
        deep_stop_in <= 1'b0;
        $display("test hardware trigger done");
    endtask

    task final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_pins();
        t_inner();
        t_off();
        t_abort_fmt();
        t_cmp_irq();
        t_clk_stop();
        t_hw();
        final_report();
    end
endmodule
